// File: verilog/txcal_regs.sv
// TX power selection, ramp sequencer and synthesizer calibration result registers
`timescale 1ns/1ps
module txcal_regs
  import txcal_pkg::*;
#(
  parameter int STEP_CYCLES = TXCAL_RAMP_STEP_CYCLES,
  parameter int CAL_CYCLES = TXCAL_CAL_STAGE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  // Register port from the serial interface decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Transmit control (same clock domain)
  input wire logic tx_enable,
  input wire logic tx_ook_mode,
  input wire logic tx_symbol,
  // Calibration control and analog results (same clock domain)
  input wire logic cal_start,
  input wire logic [3:0] cal_pump_result,
  input wire logic [4:0] cal_osc_result,
  input wire logic [5:0] cal_coarse_result,
  output logic cal_busy,
  output logic cal_pump_stage,
  // Analog control outputs
  output logic [7:0] pa_setting,
  output logic pa_active,
  output logic [1:0] tx_lo_buffer_bias,
  output logic [1:0] cal_config,
  output logic [3:0] pump_current_code,
  output logic oscillator_core_high_select,
  output logic [4:0] osc_current_code,
  output logic [5:0] coarse_tune_code
);
  // ========================================================================
  // Parameter checks
  initial begin
    // The dwell and stage counters are 16 bits wide
    if (STEP_CYCLES < 1 || STEP_CYCLES > 65536) $error("txcal_regs: STEP_CYCLES out of range");
    if (CAL_CYCLES < 1 || CAL_CYCLES > 65536) $error("txcal_regs: CAL_CYCLES out of range");
  end

  typedef enum {TXCAL_IDLE, TXCAL_RAMP_UP, TXCAL_HOLD, TXCAL_RAMP_DOWN} txcal_ramp_e;
  typedef enum {TXCAL_CAL_IDLE, TXCAL_CAL_PUMP, TXCAL_CAL_OSC} txcal_cal_e;

  logic [7:0] tx_front_end_config_reg;
  logic [7:0] synth_cal_charge_pump_reg;
  logic [7:0] synth_cal_osc_current_reg;
  logic [7:0] synth_cal_coarse_tune_reg;
  logic [2:0] tx_power_index;
  logic [1:0] pump_current_cal_stage_enable;
  logic wr_front_end;
  logic wr_charge_pump;
  logic wr_osc_current;
  logic wr_coarse_tune;
  logic wr_table;
  logic [2:0] table_ptr_reg;
  logic [7:0] table_rdata;
  logic [2:0] step_reg;
  logic [2:0] step_next;
  logic [2:0] sel_index;
  logic [15:0] dwell_reg;
  logic dwell_done;
  txcal_ramp_e ramp_reg;
  txcal_cal_e cal_reg;
  logic [15:0] cal_cnt_reg;
  logic cal_done;
  logic cal_active;

  // ========================================================================
  // Field views
  assign tx_power_index = tx_front_end_config_reg[TXCAL_POS_POWER_INDEX +: 3];
  assign pump_current_cal_stage_enable =
    synth_cal_charge_pump_reg[TXCAL_POS_PUMP_STAGE_EN +: 2];
  assign wr_front_end = reg_wr && (reg_addr == TXCAL_ADDR_FRONT_END);
  assign wr_charge_pump = reg_wr && (reg_addr == TXCAL_ADDR_CHARGE_PUMP);
  assign wr_osc_current = reg_wr && (reg_addr == TXCAL_ADDR_OSC_CURRENT);
  assign wr_coarse_tune = reg_wr && (reg_addr == TXCAL_ADDR_COARSE_TUNE);
  assign wr_table = reg_wr && (reg_addr == TXCAL_ADDR_POWER_TABLE);
  assign cal_active = (cal_reg != TXCAL_CAL_IDLE);

  // ========================================================================
  // Front end configuration; reserved bits masked off on write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_front_end_config_reg <= TXCAL_RST_FRONT_END;
    end else if (wr_front_end) begin
      tx_front_end_config_reg <= reg_wdata & TXCAL_MASK_FRONT_END;
    end
  end

  // Charge pump register: host write or calibration result capture.
  // A host write in the same cycle as a capture wins, since it is an override.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      synth_cal_charge_pump_reg <= TXCAL_RST_CHARGE_PUMP;
    end else if (wr_charge_pump) begin
      synth_cal_charge_pump_reg <= reg_wdata & TXCAL_MASK_CHARGE_PUMP;
    end else if (cal_reg == TXCAL_CAL_PUMP && cal_done) begin
      synth_cal_charge_pump_reg[TXCAL_POS_PUMP_RESULT +: 4] <= cal_pump_result;
    end
  end

  // Oscillator current register: result stored by calibration, override by host
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      synth_cal_osc_current_reg <= TXCAL_RST_OSC_CURRENT;
    end else if (wr_osc_current) begin
      synth_cal_osc_current_reg <= reg_wdata & TXCAL_MASK_OSC_CURRENT;
    end else if (cal_reg == TXCAL_CAL_OSC && cal_done) begin
      synth_cal_osc_current_reg[TXCAL_POS_OSC_CURRENT +: 5] <= cal_osc_result;
    end
  end

  // Coarse tune register, saved and restored with the other two for hopping
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      synth_cal_coarse_tune_reg <= TXCAL_RST_COARSE_TUNE;
    end else if (wr_coarse_tune) begin
      synth_cal_coarse_tune_reg <= reg_wdata & TXCAL_MASK_COARSE_TUNE;
    end else if (cal_reg == TXCAL_CAL_OSC && cal_done) begin
      synth_cal_coarse_tune_reg[TXCAL_POS_COARSE_TUNE +: 6] <= cal_coarse_result;
    end
  end

  // ========================================================================
  // Power table access: each table access advances an internal pointer,
  // so a burst fills entries 0..7 in order. Any other register access
  // rewinds it, which keeps burst writes predictable.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      table_ptr_reg <= 3'h0;
    end else if ((reg_wr || reg_rd) && reg_addr == TXCAL_ADDR_POWER_TABLE) begin
      table_ptr_reg <= table_ptr_reg + 3'h1;
    end else if (reg_wr || reg_rd) begin
      table_ptr_reg <= 3'h0;
    end
  end

  // ========================================================================
  // Ramp sequencer: step through entries 0..index at start and back at end
  assign dwell_done = (dwell_reg == 16'(STEP_CYCLES - 1));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dwell_reg <= 16'h0000;
    end else if (ramp_reg == TXCAL_IDLE || ramp_reg == TXCAL_HOLD || dwell_done) begin
      dwell_reg <= 16'h0000;
    end else begin
      dwell_reg <= dwell_reg + 16'h0001;
    end
  end

  always_comb begin
    step_next = step_reg;
    unique case (ramp_reg)
      TXCAL_IDLE: step_next = 3'h0;
      TXCAL_RAMP_UP: if (dwell_done && step_reg != tx_power_index) step_next = step_reg + 3'h1;
      TXCAL_HOLD: step_next = tx_power_index;
      TXCAL_RAMP_DOWN: if (dwell_done && step_reg != 3'h0) step_next = step_reg - 3'h1;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ramp_reg <= TXCAL_IDLE;
      step_reg <= 3'h0;
    end else begin
      step_reg <= step_next;
      unique case (ramp_reg)
        TXCAL_IDLE: if (tx_enable) ramp_reg <= TXCAL_RAMP_UP;
        TXCAL_RAMP_UP: begin
          if (!tx_enable) ramp_reg <= TXCAL_RAMP_DOWN;
          else if (dwell_done && step_reg == tx_power_index) ramp_reg <= TXCAL_HOLD;
        end
        TXCAL_HOLD: if (!tx_enable) ramp_reg <= TXCAL_RAMP_DOWN;
        TXCAL_RAMP_DOWN: begin
          if (tx_enable) ramp_reg <= TXCAL_RAMP_UP;
          else if (dwell_done && step_reg == 3'h0) ramp_reg <= TXCAL_IDLE;
        end
      endcase
    end
  end

  // Entry select: keyed symbol choice in the OOK hold phase, index in plain hold, ramp step otherwise
  always_comb begin
    if (ramp_reg == TXCAL_HOLD && tx_ook_mode) begin
      sel_index = tx_symbol ? tx_power_index : 3'h0;
    end else if (ramp_reg == TXCAL_HOLD) begin
      sel_index = tx_power_index;
    end else begin
      sel_index = step_reg;
    end
  end

  // Shared memory: read port serves either the PA or a host read.
  // Host reads steal one cycle of PA update; the PA output then holds.
  logic host_table_rd;
  logic host_table_rd_reg;
  assign host_table_rd = reg_rd && (reg_addr == TXCAL_ADDR_POWER_TABLE);

  txcal_table_mem #(
    .DEPTH(8),
    .AW(3)
  ) u_table (
    .clock(clock),
    .rst(rst),
    .wr_en(wr_table),
    .wr_addr(table_ptr_reg),
    .wr_data(reg_wdata),
    .rd_addr(host_table_rd ? table_ptr_reg : sel_index),
    .rd_data(table_rdata)
  );

  // PA drive outputs, registered: setting from the table read data, active flag from the ramp state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      host_table_rd_reg <= 1'b0;
      pa_setting <= TXCAL_RST_TABLE_ENTRY;
      pa_active <= 1'b0;
    end else begin
      host_table_rd_reg <= host_table_rd;
      if (!host_table_rd_reg) pa_setting <= table_rdata;
      pa_active <= (ramp_reg != TXCAL_IDLE);
    end
  end

  // ========================================================================
  // Calibration sequencer: pump stage only when enable field equals one
  assign cal_done = (cal_cnt_reg == 16'(CAL_CYCLES - 1));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cal_reg <= TXCAL_CAL_IDLE;
      cal_cnt_reg <= 16'h0000;
    end else begin
      cal_cnt_reg <= (cal_active && !cal_done) ? cal_cnt_reg + 16'h0001 : 16'h0000;
      unique case (cal_reg)
        TXCAL_CAL_IDLE: if (cal_start) begin
          cal_reg <= (pump_current_cal_stage_enable == TXCAL_PUMP_STAGE_ON) ?
                     TXCAL_CAL_PUMP : TXCAL_CAL_OSC;
        end
        TXCAL_CAL_PUMP: if (cal_done) cal_reg <= TXCAL_CAL_OSC;
        TXCAL_CAL_OSC: if (cal_done) cal_reg <= TXCAL_CAL_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Register read port: one cycle latency for all addresses; unmapped reads zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  logic [5:0] rd_addr_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_addr_reg <= 6'h00;
    end else if (reg_rd) begin
      rd_addr_reg <= reg_addr;
    end
  end

  // Snapshot of each register at read time so read data is stable with rvalid
  logic [7:0] tx_front_end_config_reg_q;
  logic [7:0] synth_cal_charge_pump_reg_q;
  logic [7:0] synth_cal_osc_current_reg_q;
  logic [7:0] synth_cal_coarse_tune_reg_q;

  // Table data arrives from the memory register, so the mux is combinational on it
  always_comb begin
    unique case (rd_addr_reg)
      TXCAL_ADDR_FRONT_END: reg_rdata = tx_front_end_config_reg_q;
      TXCAL_ADDR_CHARGE_PUMP: reg_rdata = synth_cal_charge_pump_reg_q;
      TXCAL_ADDR_OSC_CURRENT: reg_rdata = synth_cal_osc_current_reg_q;
      TXCAL_ADDR_COARSE_TUNE: reg_rdata = synth_cal_coarse_tune_reg_q;
      TXCAL_ADDR_POWER_TABLE: reg_rdata = table_rdata;
      default: reg_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_front_end_config_reg_q <= TXCAL_RST_FRONT_END;
      synth_cal_charge_pump_reg_q <= TXCAL_RST_CHARGE_PUMP;
      synth_cal_osc_current_reg_q <= TXCAL_RST_OSC_CURRENT;
      synth_cal_coarse_tune_reg_q <= TXCAL_RST_COARSE_TUNE;
    end else if (reg_rd) begin
      tx_front_end_config_reg_q <= tx_front_end_config_reg;
      synth_cal_charge_pump_reg_q <= synth_cal_charge_pump_reg;
      synth_cal_osc_current_reg_q <= synth_cal_osc_current_reg;
      synth_cal_coarse_tune_reg_q <= synth_cal_coarse_tune_reg;
    end
  end

  // ========================================================================
  // Analog control outputs, all registered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_lo_buffer_bias <= TXCAL_RST_FRONT_END[TXCAL_POS_LO_BIAS +: 2];
      cal_config <= TXCAL_RST_CHARGE_PUMP[TXCAL_POS_CAL_CONFIG +: 2];
      pump_current_code <= TXCAL_RST_CHARGE_PUMP[TXCAL_POS_PUMP_RESULT +: 4];
      oscillator_core_high_select <= TXCAL_RST_OSC_CURRENT[TXCAL_POS_CORE_HIGH];
      osc_current_code <= TXCAL_RST_OSC_CURRENT[TXCAL_POS_OSC_CURRENT +: 5];
      coarse_tune_code <= TXCAL_RST_COARSE_TUNE[TXCAL_POS_COARSE_TUNE +: 6];
      cal_busy <= 1'b0;
      cal_pump_stage <= 1'b0;
    end else begin
      tx_lo_buffer_bias <= tx_front_end_config_reg[TXCAL_POS_LO_BIAS +: 2];
      cal_config <= synth_cal_charge_pump_reg[TXCAL_POS_CAL_CONFIG +: 2];
      pump_current_code <= synth_cal_charge_pump_reg[TXCAL_POS_PUMP_RESULT +: 4];
      oscillator_core_high_select <= synth_cal_osc_current_reg[TXCAL_POS_CORE_HIGH];
      osc_current_code <= synth_cal_osc_current_reg[TXCAL_POS_OSC_CURRENT +: 5];
      coarse_tune_code <= synth_cal_coarse_tune_reg[TXCAL_POS_COARSE_TUNE +: 6];
      cal_busy <= cal_active;
      cal_pump_stage <= (cal_reg == TXCAL_CAL_PUMP);
    end
  end
endmodule

// File: verilog/txcal_pkg.sv
// Package: register map, field layout, reset values and timing for the TX power / cal bank
// ==========================================================================
package txcal_pkg;
  // ========================================================================
  // Register offsets
  localparam logic [5:0] TXCAL_ADDR_FRONT_END = 6'h22;
  localparam logic [5:0] TXCAL_ADDR_CHARGE_PUMP = 6'h23;
  localparam logic [5:0] TXCAL_ADDR_OSC_CURRENT = 6'h24;
  localparam logic [5:0] TXCAL_ADDR_COARSE_TUNE = 6'h25;
  localparam logic [5:0] TXCAL_ADDR_POWER_TABLE = 6'h3e;
  // ========================================================================
  // Writable-bit masks (reserved bits zero)
  localparam logic [7:0] TXCAL_MASK_FRONT_END = 8'h37;
  localparam logic [7:0] TXCAL_MASK_CHARGE_PUMP = 8'hff;
  localparam logic [7:0] TXCAL_MASK_OSC_CURRENT = 8'h3f;
  localparam logic [7:0] TXCAL_MASK_COARSE_TUNE = 8'h3f;
  // ========================================================================
  // Reset values
  localparam logic [7:0] TXCAL_RST_FRONT_END = 8'h10;
  localparam logic [7:0] TXCAL_RST_CHARGE_PUMP = 8'ha9;
  localparam logic [7:0] TXCAL_RST_OSC_CURRENT = 8'h0a;
  localparam logic [7:0] TXCAL_RST_COARSE_TUNE = 8'h20;
  localparam logic [7:0] TXCAL_RST_TABLE_ENTRY = 8'h00;
  // ========================================================================
  // Field positions
  localparam int TXCAL_POS_POWER_INDEX = 0;
  localparam int TXCAL_POS_LO_BIAS = 4;
  localparam int TXCAL_POS_PUMP_RESULT = 0;
  localparam int TXCAL_POS_PUMP_STAGE_EN = 4;
  localparam int TXCAL_POS_CAL_CONFIG = 6;
  localparam int TXCAL_POS_OSC_CURRENT = 0;
  localparam int TXCAL_POS_CORE_HIGH = 5;
  localparam int TXCAL_POS_COARSE_TUNE = 0;
  localparam logic [1:0] TXCAL_PUMP_STAGE_ON = 2'h1;
  // ========================================================================
  // Timing: dwell on each ramp step
  localparam int TXCAL_CLK_MHZ = 125;
  localparam int TXCAL_RAMP_STEP_NS = 1000;
  localparam int TXCAL_RAMP_STEP_CYCLES = (TXCAL_RAMP_STEP_NS * TXCAL_CLK_MHZ) / 1000;
  // Calibration stage durations in clock cycles
  localparam int TXCAL_CAL_STAGE_CYCLES = 64;

  typedef enum logic [1:0] {TXCAL_MOD_FSK, TXCAL_MOD_OOK} txcal_mod_e;
endpackage

// File: verilog/txcal_table_mem.sv
// Eight-entry power level table memory with registered read port
`timescale 1ns/1ps
module txcal_table_mem
  import txcal_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  // ========================================================================
  // Storage
  logic [7:0] mem_reg [DEPTH];

  initial begin
    if (DEPTH != (1 << AW)) $error("txcal_table_mem: DEPTH must equal 2**AW");
  end

  // Write port; entries clear on reset so the PA starts silent
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= TXCAL_RST_TABLE_ENTRY;
      end
    end else if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= TXCAL_RST_TABLE_ENTRY;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule

// File: verification/txcal_regs_asserts.sv
// Checker for the TX power and synthesizer calibration register bank
`timescale 1ns/1ps
module txcal_regs_asserts
  import txcal_pkg::*;
#(
  parameter int STEP_CYCLES = 2,
  parameter int CAL_CYCLES = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic cal_start,
  input wire logic cal_busy,
  input wire logic [1:0] tx_lo_buffer_bias,
  input wire logic [1:0] cal_config,
  input wire logic [3:0] pump_current_code,
  input wire logic oscillator_core_high_select,
  input wire logic [4:0] osc_current_code,
  input wire logic [5:0] coarse_tune_code
);
  // ==========================================================================
  // Helpers: write data delayed three edges, so field copies can be compared
  logic [7:0] wd1;
  logic [7:0] wd2;
  logic [7:0] wd3;
  logic mapped;
  logic quiet_wr;
  assign mapped = reg_addr inside {6'h22, 6'h23, 6'h24, 6'h25, 6'h3e};
  // A capture by calibration may overlap a write, so only idle writes are judged
  assign quiet_wr = reg_wr && !cal_busy;
  always_ff @(posedge clock) begin
    wd1 <= reg_wdata;
    wd2 <= wd1;
    wd3 <= wd2;
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Properties
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  chk_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_lo_bias_copy: assert property (quiet_wr && reg_addr == TXCAL_ADDR_FRONT_END
    |-> ##3 tx_lo_buffer_bias == wd3[5:4])
    else $error("bias field not applied");
  chk_cal_config_copy: assert property (quiet_wr && reg_addr == TXCAL_ADDR_CHARGE_PUMP
    |-> ##3 cal_config == wd3[7:6])
    else $error("cal config not applied");
  chk_pump_code_copy: assert property (quiet_wr && reg_addr == TXCAL_ADDR_CHARGE_PUMP
    |-> ##3 pump_current_code == wd3[3:0])
    else $error("pump code not applied");
  chk_core_select_copy: assert property (quiet_wr && reg_addr == TXCAL_ADDR_OSC_CURRENT
    |-> ##3 oscillator_core_high_select == wd3[5])
    else $error("core select not applied");
  chk_osc_code_copy: assert property (quiet_wr && reg_addr == TXCAL_ADDR_OSC_CURRENT
    |-> ##3 osc_current_code == wd3[4:0])
    else $error("osc code not applied");
  chk_coarse_code_copy: assert property (quiet_wr && reg_addr == TXCAL_ADDR_COARSE_TUNE
    |-> ##3 coarse_tune_code == wd3[5:0])
    else $error("coarse code not applied");
  chk_cal_busy_start: assert property (cal_start && !cal_busy |-> ##[1:2] cal_busy)
    else $error("calibration did not start");
endmodule

bind txcal_regs txcal_regs_asserts #(.STEP_CYCLES(STEP_CYCLES), .CAL_CYCLES(CAL_CYCLES)) u_chk (
  .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .cal_start(cal_start), .cal_busy(cal_busy), .tx_lo_buffer_bias(tx_lo_buffer_bias),
  .cal_config(cal_config), .pump_current_code(pump_current_code),
  .oscillator_core_high_select(oscillator_core_high_select),
  .osc_current_code(osc_current_code), .coarse_tune_code(coarse_tune_code));

// File: verification/txcal_host_model.sv
// Host model that drives the register port as the serial decoder would
`timescale 1ns/1ps
module txcal_host_model (
  input wire logic clock,
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // ==========================================================================
  // Idle port: strobes low, address and data parked on a meaningless pattern
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h15;
    reg_wdata = 8'h5a;
  end
  // One byte write; tool values for bias, cal config and saved results go this way
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d; // Released data never shows the stale value
  endtask
  // One byte read; the answer stands only in the cycle after the read edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
endmodule

// File: verification/testbench.sv
// Self-checking testbench for the TX power and calibration register bank
`timescale 1ns/1ps
module testbench;
  import txcal_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_wr;
  logic reg_rd;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic tx_enable = 1'b0;
  logic tx_ook_mode = 1'b0;
  logic tx_symbol = 1'b0;
  logic cal_start = 1'b0;
  logic [3:0] cal_pump_result = 4'hc;
  logic [4:0] cal_osc_result = 5'h17;
  logic [5:0] cal_coarse_result = 6'h2b;
  logic cal_busy;
  logic cal_pump_stage;
  logic [7:0] pa_setting;
  logic pa_active;
  logic [1:0] tx_lo_buffer_bias;
  logic [1:0] cal_config;
  logic [3:0] pump_current_code;
  logic oscillator_core_high_select;
  logic [4:0] osc_current_code;
  logic [5:0] coarse_tune_code;
  int bad_count = 0;
  int n_checks = 0;
  // ==========================================================================
  // Clock, design and host
  always #4 clock = ~clock;
  txcal_regs #(.STEP_CYCLES(2), .CAL_CYCLES(2)) uut (.clock(clock), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .tx_enable(tx_enable),
    .tx_ook_mode(tx_ook_mode), .tx_symbol(tx_symbol), .cal_start(cal_start),
    .cal_pump_result(cal_pump_result), .cal_osc_result(cal_osc_result),
    .cal_coarse_result(cal_coarse_result), .cal_busy(cal_busy),
    .cal_pump_stage(cal_pump_stage), .pa_setting(pa_setting), .pa_active(pa_active),
    .tx_lo_buffer_bias(tx_lo_buffer_bias), .cal_config(cal_config),
    .pump_current_code(pump_current_code),
    .oscillator_core_high_select(oscillator_core_high_select),
    .osc_current_code(osc_current_code), .coarse_tune_code(coarse_tune_code));
  txcal_host_model host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  // ==========================================================================
  // Shared checks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Track distinct non-zero power values; zero may be the idle output, so it is skipped
  task automatic ramp_watch(input logic [7:0] from, input logic [7:0] exp[$]);
    int k;
    logic [7:0] last;
    k = 0;
    last = from;
    repeat (60) begin
      @(posedge clock);
      #1;
      if (pa_setting !== last && pa_setting !== 8'h00) begin
        if (k < exp.size()) check(pa_setting, exp[k]);
        k++;
        last = pa_setting;
      end
    end
    check(8'(k), 8'(exp.size()));
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset_and_masks();
    rd_chk(TXCAL_ADDR_FRONT_END, 8'h10);
    rd_chk(TXCAL_ADDR_CHARGE_PUMP, 8'ha9);
    rd_chk(TXCAL_ADDR_OSC_CURRENT, 8'h0a);
    rd_chk(TXCAL_ADDR_COARSE_TUNE, 8'h20);
    host.wr(TXCAL_ADDR_FRONT_END, 8'hff);
    rd_chk(TXCAL_ADDR_FRONT_END, 8'h37);
    host.wr(TXCAL_ADDR_CHARGE_PUMP, 8'hff);
    rd_chk(TXCAL_ADDR_CHARGE_PUMP, 8'hff);
    host.wr(TXCAL_ADDR_OSC_CURRENT, 8'hff);
    rd_chk(TXCAL_ADDR_OSC_CURRENT, 8'h3f);
    host.wr(TXCAL_ADDR_COARSE_TUNE, 8'hff);
    rd_chk(TXCAL_ADDR_COARSE_TUNE, 8'h3f);
    host.wr(6'h30, 8'ha5);
    rd_chk(6'h30, 8'h00);
  endtask
  // Fill the table, then ramp up to the index and back down to entry zero
  task automatic t_ramp(input logic [2:0] idx);
    logic [7:0] up[$];
    logic [7:0] dn[$];
    for (int i = 1; i <= idx; i++) begin
      up.push_back(8'h40 + 8'(i));
      dn.push_front(8'h40 + 8'(i - 1));
    end
    rd_chk(TXCAL_ADDR_COARSE_TUNE, 8'h3f);
    for (int i = 0; i < 8; i++) host.wr(TXCAL_ADDR_POWER_TABLE, 8'h40 + 8'(i));
    // The index write and its readback also rewind the table pointer
    host.wr(TXCAL_ADDR_FRONT_END, {5'h02, idx});
    rd_chk(TXCAL_ADDR_FRONT_END, {5'h02, idx});
    for (int i = 0; i < 8; i++) rd_chk(TXCAL_ADDR_POWER_TABLE, 8'h40 + 8'(i));
    tx_enable = 1'b1;
    ramp_watch(8'h40, up);
    check(pa_setting, 8'h40 + 8'(idx));
    tx_enable = 1'b0;
    ramp_watch(8'h40 + 8'(idx), dn);
    check(8'(pa_active), 8'h00);
  endtask
  // Keyed transmission: ones at the indexed entry, zeros at entry zero
  task automatic t_ook();
    tx_ook_mode = 1'b1;
    tx_symbol = 1'b1;
    tx_enable = 1'b1;
    repeat (40) @(posedge clock);
    #1 check(pa_setting, 8'h43);
    tx_symbol = 1'b0;
    repeat (20) @(posedge clock);
    #1 check(pa_setting, 8'h40);
    tx_symbol = 1'b1;
    repeat (20) @(posedge clock);
    #1 check(pa_setting, 8'h43);
    tx_enable = 1'b0;
    tx_ook_mode = 1'b0;
    repeat (40) @(posedge clock);
  endtask
  // Calibration with the pump stage on or off, results read back afterwards
  task automatic t_cal(input logic [7:0] cfg, input logic stage, input logic [7:0] exp23);
    logic saw;
    int n;
    saw = 1'b0;
    n = 0;
    host.wr(TXCAL_ADDR_CHARGE_PUMP, cfg);
    host.wr(TXCAL_ADDR_OSC_CURRENT, 8'h20);
    @(posedge clock);
    #1 cal_start = 1'b1;
    @(posedge clock);
    #1 cal_start = 1'b0;
    do begin
      @(posedge clock);
      #1;
      if (cal_pump_stage === 1'b1) saw = 1'b1;
      n++;
    end while ((cal_busy !== 1'b0 || n < 3) && n < 500);
    check(8'(saw), 8'(stage));
    rd_chk(TXCAL_ADDR_CHARGE_PUMP, exp23);
    rd_chk(TXCAL_ADDR_OSC_CURRENT, 8'h37);
    rd_chk(TXCAL_ADDR_COARSE_TUNE, 8'h2b);
    check(8'(pump_current_code), 8'(exp23[3:0]));
  endtask
  // Saved results written back for a hop are applied without calibrating
  task automatic t_hop();
    host.wr(TXCAL_ADDR_CHARGE_PUMP, 8'h96);
    host.wr(TXCAL_ADDR_OSC_CURRENT, 8'h25);
    host.wr(TXCAL_ADDR_COARSE_TUNE, 8'h11);
    repeat (3) @(posedge clock);
    #1 check(8'(pump_current_code), 8'h06);
    check(8'(osc_current_code), 8'h05);
    check(8'(oscillator_core_high_select), 8'h01);
    check(8'(coarse_tune_code), 8'h11);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    t_reset_and_masks();
    t_ramp(3'd3);
    t_ook();
    t_ramp(3'd7);
    t_cal(8'h95, 1'b1, 8'h9c);
    t_cal(8'ha5, 1'b0, 8'ha5);
    t_hop();
    summarize();
  end
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule
